//--- verilog/mado_regs.vh
// register offsets, field positions, reset values and startup method codes
// for the motor algorithm debug speed_source_a register bank.
// assumes a byte-addressed register space with 8-bit offsets.
`ifndef MADO_REGS_VH
`define MADO_REGS_VH

// register offsets within the algorithm control group
`define MADO_OFF_CTRL_ONE       8'hEC
`define MADO_OFF_CTRL_TWO       8'hEE
`define MADO_NUM_REGS           2
`define MADO_ADDR_W             8
`define MADO_DATA_W             32

// reset values, both registers clear to zero
`define MADO_RST_CTRL_ONE       32'h00000000
`define MADO_RST_CTRL_TWO       32'h00000000

// field positions of the first debug register
`define MADO_BIT_SPEED_SRC      31
`define MADO_SPEED_HI           30
`define MADO_SPEED_LO           16
`define MADO_SPEED_W            15
`define MADO_BIT_CL_DIS         15
`define MADO_BIT_HOLD_ALIGN     14
`define MADO_BIT_HOLD_SLOW      13
`define MADO_BIT_HOLD_IPD       12
`define MADO_BIT_HOLD_ISD       11
`define MADO_BIT_ANGLE_SRC      10
`define MADO_IQ_HI              9
`define MADO_IQ_LO              0
`define MADO_IQ_W               10

// torque setpoint decode limits; one code is 10/500 of a unit of current
`define MADO_IQ_POS_MAX         10'h1F4
`define MADO_IQ_NEG_BASE        10'h200
`define MADO_IQ_NEG_MAX         10'h3E8
`define MADO_IQ_OUT_W           11

// align angle handling, degrees
`define MADO_ANGLE_W            9
`define MADO_ANGLE_WRAP         9'h168

// startup method codes as presented by the configuration logic
`define MADO_STARTUP_W          2
`define MADO_STARTUP_ALIGN      2'h0
`define MADO_STARTUP_DBL_ALIGN  2'h1
`define MADO_STARTUP_SLOW_FIRST 2'h2
`define MADO_STARTUP_IPD        2'h3

`endif

//--- verilog/mado_word_reg.v
// one write-only configuration word with a synchronous load strobe.
// assumes the caller decodes the address and that writes are whole words.
`timescale 1ns/10ps
`include "mado_regs.vh"

module mado_word_reg #(
  parameter [`MADO_DATA_W-1:0] RESET_VALUE = `MADO_RST_CTRL_ONE
) (
  input  wire                    ref_clk,
  input  wire                    sys_rst,
  input  wire                    wr_en,
  input  wire [`MADO_DATA_W-1:0] wr_data,
  output reg  [`MADO_DATA_W-1:0] q
);

////////////////////////////////////////////////////////////////////////////
// storage: a held value, loaded only on the strobe
always @(posedge ref_clk or posedge sys_rst) begin
  if (sys_rst) begin
    q <= RESET_VALUE;
  end else if (wr_en) begin
    q <= wr_data;
  end
end

endmodule // mado_word_reg

//--- verilog/mado_debug_regs.v
// debug speed_source_a register bank for the sensorless motor control algorithm.
// assumes the serial configuration engine and the algorithm logic run on
// ref_clk, so their signals enter here without synchronisers.
//
// What this block does
// - speed_source_a bit 31 selects serial speed command
// - speed_source_a clear uses pin-derived speed command
// - bits 30..16 form the serial speed command
// - bit 15 forces open-loop commutation
// - bit 14 holds align for align startups
// - bit 13 holds slow first cycle state
// - bit 12 holds initial position detect state
// - bit 11 holds speed detect when enabled
// - bit 10 picks runtime or configured angle
// - setpoint drives torque reference when loop off
// - decode setpoint, codes 512 to 1000 negative
// - second debug register at EEh, resets zero
// - first debug register lives at ECh
// - runtime align angle applied modulo 360
`timescale 1ns/10ps
`include "mado_regs.vh"

module mado_debug_regs (
  input  wire                       ref_clk,
  input  wire                       sys_rst,
  input  wire                       cfg_wr_en,
  input  wire [`MADO_ADDR_W-1:0]    cfg_wr_addr,
  input  wire [`MADO_DATA_W-1:0]    cfg_wr_data,
  input  wire [`MADO_SPEED_W-1:0]   pin_speed_cmd,
  input  wire [`MADO_STARTUP_W-1:0] startup_method,
  input  wire                       speed_detect_enable,
  input  wire [`MADO_ANGLE_W-1:0]   runtime_align_angle,
  input  wire [`MADO_ANGLE_W-1:0]   config_align_angle,
  input  wire                       speed_loop_disable,
  output reg                        cfg_wr_ack,
  output reg                        cfg_wr_unmapped,
  output reg                        speed_source_a,
  output reg  [`MADO_SPEED_W-1:0]   speed_command,
  output reg                        closed_loop_disable,
  output reg                        hold_align,
  output reg                        hold_slow_first_cycle,
  output reg                        hold_position_detect,
  output reg                        hold_speed_detect,
  output reg                        align_angle_source,
  output reg  [`MADO_ANGLE_W-1:0]   align_angle_deg,
  output reg                        torque_ref_active,
  output reg  [`MADO_IQ_OUT_W-1:0]  torque_current_reference,
  output reg                        setpoint_invalid,
  output reg  [`MADO_DATA_W-1:0]    algo_debug_control_two
);

////////////////////////////////////////////////////////////////////////////
// address decode and register storage

wire [`MADO_NUM_REGS-1:0] reg_hit;
wire [`MADO_DATA_W-1:0]   reg_q [0:`MADO_NUM_REGS-1];
wire [`MADO_DATA_W-1:0]   algo_debug_control_one;

// one word per entry; index 0 sits at ECh, index 1 at EEh
genvar gi;
generate
  for (gi = 0; gi < `MADO_NUM_REGS; gi = gi + 1) begin : g_reg
    localparam [`MADO_ADDR_W-1:0] OFFSET =
      (gi == 0) ? `MADO_OFF_CTRL_ONE : `MADO_OFF_CTRL_TWO;
    localparam [`MADO_DATA_W-1:0] RSTVAL =
      (gi == 0) ? `MADO_RST_CTRL_ONE : `MADO_RST_CTRL_TWO;

    assign reg_hit[gi] = cfg_wr_en && (cfg_wr_addr == OFFSET);

    mado_word_reg #(
      .RESET_VALUE (RSTVAL)
    ) u_word (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .wr_en   (reg_hit[gi]),
      .wr_data (cfg_wr_data),
      .q       (reg_q[gi])
    );
  end
endgenerate

assign algo_debug_control_one = reg_q[0];

////////////////////////////////////////////////////////////////////////////
// write handshake: one-cycle ack for a mapped word, one-cycle flag for
// any other write address, in the group or not; there is no read path at all

reg next_cfg_wr_ack;
reg next_cfg_wr_unmapped;

always @* begin
  next_cfg_wr_ack      = |reg_hit;
  next_cfg_wr_unmapped = cfg_wr_en && ~(|reg_hit);
end

////////////////////////////////////////////////////////////////////////////
// field extraction from the first debug register

wire                     fld_speed_src;
wire [`MADO_SPEED_W-1:0] fld_speed;
wire                     fld_cl_dis;
wire                     fld_hold_align;
wire                     fld_hold_slow;
wire                     fld_hold_ipd;
wire                     fld_hold_isd;
wire                     fld_angle_src;
wire [`MADO_IQ_W-1:0]    fld_iq;

assign fld_speed_src  = algo_debug_control_one[`MADO_BIT_SPEED_SRC];
assign fld_speed      =
  algo_debug_control_one[`MADO_SPEED_HI:`MADO_SPEED_LO];
assign fld_cl_dis     = algo_debug_control_one[`MADO_BIT_CL_DIS];
assign fld_hold_align = algo_debug_control_one[`MADO_BIT_HOLD_ALIGN];
assign fld_hold_slow  = algo_debug_control_one[`MADO_BIT_HOLD_SLOW];
assign fld_hold_ipd   = algo_debug_control_one[`MADO_BIT_HOLD_IPD];
assign fld_hold_isd   = algo_debug_control_one[`MADO_BIT_HOLD_ISD];
assign fld_angle_src  = algo_debug_control_one[`MADO_BIT_ANGLE_SRC];
assign fld_iq         = algo_debug_control_one[`MADO_IQ_HI:`MADO_IQ_LO];

////////////////////////////////////////////////////////////////////////////
// speed command source select

reg [`MADO_SPEED_W-1:0] next_speed_command;

// the serial value replaces the pin path outright; no blending, so a
// change of source steps the command in a single cycle
always @* begin
  if (fld_speed_src) begin
    next_speed_command = fld_speed;
  end else begin
    next_speed_command = pin_speed_cmd;
  end
end

////////////////////////////////////////////////////////////////////////////
// startup state holds, qualified by the active startup method or, for speed detect, by its enable

reg next_hold_align;
reg next_hold_slow;
reg next_hold_ipd;
reg next_hold_isd;

// a hold bit whose startup method is not selected has no effect, so the
// sequencer only sees a hold it can actually honour
always @* begin
  next_hold_align = fld_hold_align &&
    ((startup_method == `MADO_STARTUP_ALIGN) ||
     (startup_method == `MADO_STARTUP_DBL_ALIGN));
  next_hold_slow  = fld_hold_slow &&
    (startup_method == `MADO_STARTUP_SLOW_FIRST);
  next_hold_ipd   = fld_hold_ipd &&
    (startup_method == `MADO_STARTUP_IPD);
  next_hold_isd   = fld_hold_isd && speed_detect_enable;
end

////////////////////////////////////////////////////////////////////////////
// align angle source and wrap

reg [`MADO_ANGLE_W-1:0] runtime_angle_wrapped;
reg [`MADO_ANGLE_W-1:0] next_align_angle;

// a 9-bit value never reaches 720, so one subtraction is a full modulo
always @* begin
  if (runtime_align_angle >= `MADO_ANGLE_WRAP) begin
    runtime_angle_wrapped = runtime_align_angle - `MADO_ANGLE_WRAP;
  end else begin
    runtime_angle_wrapped = runtime_align_angle;
  end
end

// configured angle is passed as given; only the runtime value is wrapped
always @* begin
  if (fld_angle_src) begin
    next_align_angle = runtime_angle_wrapped;
  end else begin
    next_align_angle = config_align_angle;
  end
end

////////////////////////////////////////////////////////////////////////////
// torque current setpoint decode
// the output is a signed count of 10/500 current units: the division by
// 500 and the scale of 10 are left to the consumer, which keeps this
// path free of a divider

reg                      iq_valid;
reg                      iq_negative;
reg [`MADO_IQ_W-1:0]     iq_magnitude;
reg [`MADO_IQ_OUT_W-1:0] iq_signed;

always @* begin
  iq_valid     = 1'b0;
  iq_negative  = 1'b0;
  iq_magnitude = {`MADO_IQ_W{1'b0}};
  if (fld_iq <= `MADO_IQ_POS_MAX) begin
    iq_valid     = 1'b1;
    iq_magnitude = fld_iq;
  end else if ((fld_iq >= `MADO_IQ_NEG_BASE) &&
               (fld_iq <= `MADO_IQ_NEG_MAX)) begin
    iq_valid     = 1'b1;
    iq_negative  = 1'b1;
    iq_magnitude = fld_iq - `MADO_IQ_NEG_BASE;
  end
end

// codes outside the legal ranges decode to zero rather than to a
// guessed current, and while the speed loop is off raise a flag for the fault logic
always @* begin
  if (!iq_valid) begin
    iq_signed = {`MADO_IQ_OUT_W{1'b0}};
  end else if (iq_negative) begin
    iq_signed = {`MADO_IQ_OUT_W{1'b0}} - {1'b0, iq_magnitude};
  end else begin
    iq_signed = {1'b0, iq_magnitude};
  end
end

reg                      next_torque_active;
reg [`MADO_IQ_OUT_W-1:0] next_torque_ref;
reg                      next_setpoint_invalid;

// the forced reference is only presented while the speed loop is off;
// otherwise the speed controller owns the reference and this reads zero
always @* begin
  next_torque_active    = speed_loop_disable;
  next_setpoint_invalid = speed_loop_disable && !iq_valid;
  if (speed_loop_disable) begin
    next_torque_ref = iq_signed;
  end else begin
    next_torque_ref = {`MADO_IQ_OUT_W{1'b0}};
  end
end

////////////////////////////////////////////////////////////////////////////
// output registers: every output is a flop, cleared at reset so normal
// startup and closed-loop operation apply until software writes

always @(posedge ref_clk or posedge sys_rst) begin
  if (sys_rst) begin
    cfg_wr_ack               <= 1'b0;
    cfg_wr_unmapped          <= 1'b0;
    speed_source_a           <= 1'b0;
    speed_command            <= {`MADO_SPEED_W{1'b0}};
    closed_loop_disable      <= 1'b0;
    hold_align               <= 1'b0;
    hold_slow_first_cycle    <= 1'b0;
    hold_position_detect     <= 1'b0;
    hold_speed_detect        <= 1'b0;
    align_angle_source       <= 1'b0;
    align_angle_deg          <= {`MADO_ANGLE_W{1'b0}};
    torque_ref_active        <= 1'b0;
    torque_current_reference <= {`MADO_IQ_OUT_W{1'b0}};
    setpoint_invalid         <= 1'b0;
    algo_debug_control_two   <= `MADO_RST_CTRL_TWO;
  end else begin
    cfg_wr_ack               <= next_cfg_wr_ack;
    cfg_wr_unmapped          <= next_cfg_wr_unmapped;
    speed_source_a           <= fld_speed_src;
    speed_command            <= next_speed_command;
    closed_loop_disable      <= fld_cl_dis;
    hold_align               <= next_hold_align;
    hold_slow_first_cycle    <= next_hold_slow;
    hold_position_detect     <= next_hold_ipd;
    hold_speed_detect        <= next_hold_isd;
    align_angle_source       <= fld_angle_src;
    align_angle_deg          <= next_align_angle;
    torque_ref_active        <= next_torque_active;
    torque_current_reference <= next_torque_ref;
    setpoint_invalid         <= next_setpoint_invalid;
    algo_debug_control_two   <= reg_q[1];
  end
end

endmodule // mado_debug_regs

//--- sim/mado_debug_regs_sva.sv
// checker for the debug speed_source_a register bank, bound to its top module.
// assumes one clock domain and the async, active-high reset.
`timescale 1ns/10ps
module mado_debug_regs_sva (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        cfg_wr_en,
  input wire [7:0]  cfg_wr_addr,
  input wire [31:0] cfg_wr_data,
  input wire [14:0] pin_speed_cmd,
  input wire [1:0]  startup_method,
  input wire [8:0]  config_align_angle,
  input wire        speed_loop_disable,
  input wire        cfg_wr_ack,
  input wire        cfg_wr_unmapped,
  input wire        speed_source_a,
  input wire [14:0] speed_command,
  input wire        hold_align,
  input wire        hold_slow_first_cycle,
  input wire        align_angle_source,
  input wire [8:0]  align_angle_deg,
  input wire        torque_ref_active,
  input wire [10:0] torque_current_reference,
  input wire        setpoint_invalid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire mapped = cfg_wr_addr == 8'hEC || cfg_wr_addr == 8'hEE;
  ////////////////////////////////////////////////////////////////////////////
  // speed_source_a write to register one, then a quiet cycle so it is not replaced
  sequence s_wr_one;
    cfg_wr_en && cfg_wr_addr == 8'hEC && cfg_wr_data[31];
  endsequence
  sequence s_quiet;
    !cfg_wr_en;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_ack_mapped:
  assert property (cfg_wr_en && mapped |=> cfg_wr_ack && !cfg_wr_unmapped)
    else $error("mapped write not acknowledged");
  chk_unmapped_pulse:
  assert property (cfg_wr_en && !mapped |=> cfg_wr_unmapped && !cfg_wr_ack)
    else $error("unmapped write not flagged");
  chk_serial_speed:
  assert property (s_wr_one ##1 s_quiet |=> speed_source_a &&
    speed_command == $past(cfg_wr_data[30:16], 2))
    else $error("serial speed not applied");
  // guards skip the first edge after reset, where history is from reset
  chk_pin_speed:
  assert property (!speed_source_a && !$past(sys_rst) |->
    speed_command == $past(pin_speed_cmd))
    else $error("pin speed not passed");
  chk_hold_align:
  assert property (hold_align |-> $past(startup_method) <= 2'h1)
    else $error("align hold with wrong startup");
  chk_hold_slow:
  assert property (hold_slow_first_cycle |-> $past(startup_method) == 2'h2)
    else $error("slow hold with wrong startup");
  chk_angle_cfg:
  assert property (!align_angle_source && !$past(sys_rst) |->
    align_angle_deg == $past(config_align_angle))
    else $error("configured angle not used");
  chk_loop_follow:
  assert property (!$past(sys_rst) |->
    torque_ref_active == $past(speed_loop_disable))
    else $error("torque enable not following loop");
  chk_torque_off:
  assert property (!torque_ref_active || setpoint_invalid |->
    torque_current_reference == 11'h000)
    else $error("torque reference not zero");
endmodule // mado_debug_regs_sva

//--- sim/mado_ctl_model.sv
// controller model: drives whole-word writes into the debug register bank.
// assumes writes are launched at the falling edge of ref_clk.
`timescale 1ns/10ps
module mado_ctl_model (
  input  wire        ref_clk,
  output reg         cfg_wr_en,
  output reg  [7:0]  cfg_wr_addr,
  output reg  [31:0] cfg_wr_data
);
  // idle lines at time zero
  initial begin
    cfg_wr_en = 1'b0;
    cfg_wr_addr = 8'h00;
    cfg_wr_data = 32'h00000000;
  end
  // one-cycle strobe per word; released lines show the inverse so that
  // a design sampling stale data outside the strobe is caught
  task write(input [7:0] a, input [31:0] d);
    begin
      @(negedge ref_clk);
      cfg_wr_en = 1'b1;
      cfg_wr_addr = a;
      cfg_wr_data = d;
      @(negedge ref_clk);
      cfg_wr_en = 1'b0;
      cfg_wr_addr = ~a;
      cfg_wr_data = ~d;
    end
  endtask
endmodule // mado_ctl_model

//--- sim/testbench.sv
// self-checking bench for the debug speed_source_a register bank.
// assumes the controller model drives the write port at falling edges.
`timescale 1ns/10ps
module testbench;
  reg         ref_clk, sys_rst, speed_detect_enable, speed_loop_disable;
  reg  [14:0] pin_speed_cmd;
  reg  [1:0]  startup_method;
  reg  [8:0]  runtime_align_angle, config_align_angle;
  wire        cfg_wr_en, cfg_wr_ack, cfg_wr_unmapped, speed_source_a;
  wire        closed_loop_disable, hold_align, hold_slow_first_cycle;
  wire        hold_position_detect, hold_speed_detect, align_angle_source;
  wire        torque_ref_active, setpoint_invalid;
  wire [7:0]  cfg_wr_addr;
  wire [31:0] cfg_wr_data, algo_debug_control_two;
  wire [14:0] speed_command;
  wire [8:0]  align_angle_deg;
  wire [10:0] torque_current_reference;
  integer     err_total, checked, i;
  reg  [31:0] r, w;
  reg  [9:0]  c;
  mado_ctl_model i_mado_ctl_model (.ref_clk, .cfg_wr_en, .cfg_wr_addr,
    .cfg_wr_data);
  mado_debug_regs i_mado_debug_regs (.ref_clk, .sys_rst, .cfg_wr_en,
    .cfg_wr_addr, .cfg_wr_data, .pin_speed_cmd, .startup_method,
    .speed_detect_enable, .runtime_align_angle, .config_align_angle,
    .speed_loop_disable, .cfg_wr_ack, .cfg_wr_unmapped, .speed_source_a,
    .speed_command, .closed_loop_disable, .hold_align,
    .hold_slow_first_cycle, .hold_position_detect, .hold_speed_detect,
    .align_angle_source, .align_angle_deg, .torque_ref_active,
    .torque_current_reference, .setpoint_invalid, .algo_debug_control_two);
  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  // expectations worked out from the field layout
  function bad(input [9:0] v);
    bad = (v > 10'd500 && v < 10'd512) || v > 10'd1000;
  endfunction
  function [10:0] exp_iq(input [9:0] v);
    if (!speed_loop_disable || bad(v)) exp_iq = 11'h000;
    else if (v <= 10'd500) exp_iq = {1'b0, v};
    else exp_iq = 11'h000 - (v - 10'd512);
  endfunction
  function [8:0] exp_ang(input s);
    if (!s) exp_ang = config_align_angle;
    else if (runtime_align_angle >= 9'h168)
      exp_ang = runtime_align_angle - 9'h168;
    else exp_ang = runtime_align_angle;
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (err_total == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // write one word, look at the answer pulse, then let outputs settle
  task wr(input [7:0] a, input [31:0] d);
    begin
      i_mado_ctl_model.write(a, d);
      check(cfg_wr_ack, a == 8'hEC || a == 8'hEE);
      check(cfg_wr_unmapped, a != 8'hEC && a != 8'hEE);
      @(negedge ref_clk);
    end
  endtask
  task check_one(input [31:0] v);
    begin
      check(speed_source_a, v[31]);
      check(speed_command, v[31] ? v[30:16] : pin_speed_cmd);
      check(closed_loop_disable, v[15]);
      check(hold_align, v[14] && startup_method <= 2'h1);
      check(hold_slow_first_cycle, v[13] && startup_method == 2'h2);
      check(hold_position_detect, v[12] && startup_method == 2'h3);
      check(hold_speed_detect, v[11] && speed_detect_enable);
      check(align_angle_source, v[10]);
      check(align_angle_deg, exp_ang(v[10]));
      check(torque_current_reference, exp_iq(v[9:0]));
      check(setpoint_invalid, speed_loop_disable && bad(v[9:0]));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // hang guard far beyond the roughly 190-cycle run, at about 10,000 cycles
  initial begin
    #250000;
    err_total = err_total + 1;
    report_and_stop;
  end
  // main sequence: reset, random words, code corners, second register
  initial begin
    {ref_clk, speed_detect_enable, speed_loop_disable} = 3'h0;
    {pin_speed_cmd, startup_method} = 17'h00000;
    {runtime_align_angle, config_align_angle} = 18'h00000;
    err_total = 0;
    checked = 0;
    sys_rst = 1'b1;
    r = $urandom(49);
    repeat (5) @(negedge ref_clk);
    check(algo_debug_control_two, 32'h00000000);
    check(closed_loop_disable, 1'b0);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    check_one(32'h00000000);
    for (i = 0; i < 48; i = i + 1) begin
      r = $urandom;
      {pin_speed_cmd, runtime_align_angle} = r[23:0];
      {speed_detect_enable, speed_loop_disable} = r[25:24];
      config_align_angle = r[8:0] ^ r[31:23];
      startup_method = i[1:0];
      c = $urandom % 1001;
      if (c > 10'd500 && c < 10'd512) c = c + 10'd11;
      w = {$urandom} & 32'hFFFFFC00 | c;
      wr(8'hEC, w);
      check_one(w);
    end
    // corner codes, invalid ones included on purpose, angles at the wrap
    speed_loop_disable = 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      c = {10'd0, 10'd500, 10'd501, 10'd511, 10'd512, 10'd1000, 10'd1001,
        10'd1023} >> (i * 10);
      runtime_align_angle = {9'd359, 9'd360, 9'd511, 9'd0} >> (i % 4 * 9);
      startup_method = i[1:0];
      w = {22'h3FFFFF, c};
      wr(8'hEC, w);
      check_one(w);
    end
    // last write wins, unmapped write ignored, second register raw
    wr(8'hEC, 32'h8001_5000);
    wr(8'hEC, 32'h0000_0000);
    wr(8'hED, 32'hFFFF_FFFF);
    check_one(32'h0000_0000);
    r = $urandom;
    wr(8'hEE, r);
    check(algo_debug_control_two, r);
    check_one(32'h0000_0000);
    report_and_stop;
  end
endmodule // testbench

bind mado_debug_regs mado_debug_regs_sva i_mado_debug_regs_sva (.ref_clk,
  .sys_rst, .cfg_wr_en, .cfg_wr_addr, .cfg_wr_data, .pin_speed_cmd,
  .startup_method, .config_align_angle, .speed_loop_disable, .cfg_wr_ack,
  .cfg_wr_unmapped, .speed_source_a, .speed_command, .hold_align,
  .hold_slow_first_cycle, .align_angle_source, .align_angle_deg,
  .torque_ref_active, .torque_current_reference, .setpoint_invalid);
